// ---- rtl/wrwdt_pkg.sv ----
package wrwdt_pkg;
  localparam int unsigned CLOCK_HZ          = 250_000_000;
  localparam int unsigned DEFAULT_TIMEOUT_US = 2_000;
  localparam int unsigned DEFAULT_TICKS     = (CLOCK_HZ / 1_000_000) * DEFAULT_TIMEOUT_US;
  localparam int unsigned CNT_W             = 32;
  localparam int unsigned PULSE_CYCLES      = 16;
  localparam int unsigned PULSE_W           = 5;

  typedef struct packed {
    logic             load;
    logic [CNT_W-1:0] ticks;
  } wrwdt_timeout_t;

  typedef enum logic [1:0] {
    WRWDT_IDLE,
    WRWDT_COUNT,
    WRWDT_FIRE
  } wrwdt_state_t;
endpackage

// ---- rtl/wrwdt_pulse.sv ----
`timescale 1ns/100ps
module wrwdt_pulse
  import wrwdt_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic trigger,
  output logic      pulse_out
);
  logic [PULSE_W-1:0] remain_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      remain_reg <= '0;
    end else if (trigger) begin
      remain_reg <= PULSE_W'(PULSE_CYCLES);
    end else if (remain_reg != '0) begin
      remain_reg <= remain_reg - PULSE_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= trigger || (remain_reg > PULSE_W'(1));
    end
  end
endmodule

// ---- rtl/wrwdt_top.sv ----
`timescale 1ns/100ps
// Contract
// (RULE1) leaving any reset, the timeout is the 2 ms default.
// (RULE2) after reset the watchdog is idle until software enables it; the code keeps it counting after a warm reset taken while active.
// (RULE3) a control-register enable bit write makes the watchdog active.
// (RULE4) counting starts at once; timeout may be reloaded before expiry.
// (RULE5) expiry without service issues a warm reset to the system.
// (RULE6) after its own warm reset it restarts at once with 2 ms.
// (RULE7) a warm reset discards any programmed timeout.
// (RULE8) each expiry drives a reset output pulse for board logic.
// (RULE9) power-on reset leaves it frozen until software enables it.
// (RULE10) timeout is a tick count compared with the counter every cycle.
module wrwdt_top
  import wrwdt_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             warm_rst_b,
  input  wire logic             enable_write,
  input  wire logic             enable_value,
  input  wire logic             timeout_load,
  input  wire logic [CNT_W-1:0] timeout_ticks,
  input  wire logic             kick,
  output logic                  warm_reset_req,
  output logic                  reset_out,
  output logic                  active,
  output logic [CNT_W-1:0]      count
);
  wrwdt_state_t     state_reg;
  logic [CNT_W-1:0] limit_reg;
  logic [CNT_W-1:0] count_reg;
  logic             expired;
  logic             fire_now;
  logic             warm_seen_reg;
  wrwdt_timeout_t   prog;

  assign prog.load  = timeout_load;
  assign prog.ticks = timeout_ticks;

  // compare against limit minus one so the period is exactly limit cycles
  assign expired = (state_reg == WRWDT_COUNT) &&
                   (count_reg >= limit_reg - CNT_W'(1)); // see (RULE10)

  // a disable write in the expiry cycle wins, so no reset is issued while idle
  assign fire_now = expired && !kick && warm_rst_b &&
                    !(enable_write && !enable_value); // see (RULE5)

  // remembers that the coming warm reset is ours; a foreign one leaves idle alone
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      warm_seen_reg <= 1'b0; // see (RULE9)
    end else if (warm_reset_req) begin
      warm_seen_reg <= 1'b1;
    end else if (warm_rst_b && state_reg == WRWDT_COUNT) begin
      warm_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= WRWDT_IDLE; // see (RULE2) (RULE9)
    end else if (!warm_rst_b) begin
      // warm reset from expiry keeps the timer running; it cannot stay off
      state_reg <= (state_reg == WRWDT_IDLE && !warm_seen_reg) ?
                   WRWDT_IDLE : WRWDT_COUNT; // see (RULE6)
    end else begin
      unique case (state_reg)
        WRWDT_IDLE: begin
          if (enable_write && enable_value) begin
            state_reg <= WRWDT_COUNT; // see (RULE3) (RULE4)
          end
        end
        WRWDT_COUNT: begin
          if (enable_write && !enable_value) begin
            state_reg <= WRWDT_IDLE;
          end else if (expired && !kick) begin
            state_reg <= WRWDT_FIRE; // see (RULE5)
          end
        end
        WRWDT_FIRE: begin
          state_reg <= WRWDT_COUNT;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      limit_reg <= CNT_W'(DEFAULT_TICKS); // see (RULE1)
    end else if (!warm_rst_b) begin
      limit_reg <= CNT_W'(DEFAULT_TICKS); // see (RULE7)
    end else if (prog.load && prog.ticks != '0) begin
      limit_reg <= prog.ticks; // see (RULE4)
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else if (!warm_rst_b || kick || prog.load) begin
      count_reg <= '0; // see (RULE6)
    end else if (state_reg == WRWDT_COUNT && !expired) begin
      count_reg <= count_reg + CNT_W'(1); // see (RULE4)
    end else if (state_reg != WRWDT_COUNT) begin
      count_reg <= '0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      warm_reset_req <= 1'b0;
    end else begin
      warm_reset_req <= fire_now; // see (RULE5)
    end
  end

  wrwdt_pulse u_pulse (
    .clock     (clock),
    .rst_b     (rst_b),
    .trigger   (fire_now),
    .pulse_out (reset_out)
  ); // see (RULE8)

  assign active = (state_reg != WRWDT_IDLE);
  assign count  = count_reg;
endmodule

// ---- tb/wrwdt_asserts.sv ----
`timescale 1ns/100ps
module wrwdt_asserts
  import wrwdt_pkg::*;
(
  input wire logic             clock,
  input wire logic             rst_b,
  input wire logic             warm_rst_b,
  input wire logic             enable_write,
  input wire logic             enable_value,
  input wire logic             timeout_load,
  input wire logic             kick,
  input wire logic             warm_reset_req,
  input wire logic             reset_out,
  input wire logic             active,
  input wire logic [CNT_W-1:0] count
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  stay_idle_a: assert property (!active && !enable_write |=> !active)
    else $error("left idle");
  enable_go_a: assert property (!active && enable_write && enable_value && warm_rst_b
    |=> active && count == 0) else $error("no start");
  count_up_a: assert property (
    active && warm_rst_b && !kick && !timeout_load && !enable_write && !warm_reset_req
    |=> count == $past(count) + 1 || warm_reset_req) else $error("no count");
  one_req_a: assert property (warm_reset_req |=> !warm_reset_req)
    else $error("long req");
  req_act_a: assert property (warm_reset_req |-> active) else $error("idle req");
  out_pulse_a: assert property ($rose(warm_reset_req) |-> reset_out [*8])
    else $error("short out");
  out_end_a: assert property ($rose(warm_reset_req) |-> ##15 reset_out ##1 !reset_out)
    else $error("bad out length");
  warm_keep_a: assert property (active && !warm_rst_b |=> active && count == 0)
    else $error("warm lost");
  fire_again_a: assert property (warm_reset_req |=> active && count == 0)
    else $error("no restart");
endmodule

// ---- tb/wrwdt_sys_model.sv ----
`timescale 1ns/100ps
module wrwdt_sys_model (
  input wire logic clock,
  input wire logic warm_reset_req,
  output logic     warm_rst_b = 1'h1
);
  // held 4 cycles so the restart is seen after a real reset
  always @(negedge clock) if (warm_reset_req === 1'h1) begin
    warm_rst_b <= 1'h0;
    repeat (4) @(negedge clock);
    warm_rst_b <= 1'h1;
  end
endmodule

// ---- tb/wrwdt_top_tb_top.sv ----
`timescale 1ns/100ps
module wrwdt_top_tb_top
  import wrwdt_pkg::*;
();
  logic             clock = 1'h0, rst_b = 1'h0, enable_write = 1'h0, enable_value = 1'h1;
  logic             timeout_load = 1'h0, kick = 1'h0, warm_rst_b, warm_reset_req;
  logic             reset_out, active;
  logic [CNT_W-1:0] timeout_ticks = 32'h0000_0014, count;
  int               err_count, compares, n;
  wrwdt_top dut_u (
    .clock          (clock),
    .rst_b          (rst_b),
    .warm_rst_b     (warm_rst_b),
    .enable_write   (enable_write),
    .enable_value   (enable_value),
    .timeout_load   (timeout_load),
    .timeout_ticks  (timeout_ticks),
    .kick           (kick),
    .warm_reset_req (warm_reset_req),
    .reset_out      (reset_out),
    .active         (active),
    .count          (count)
  );
  wrwdt_sys_model sys_u (
    .clock          (clock),
    .warm_reset_req (warm_reset_req),
    .warm_rst_b     (warm_rst_b)
  );
  initial forever #2 clock = ~clock;
  task automatic chk(input logic [CNT_W-1:0] got, exp);
    compares++;
    err_count += int'(got !== exp);
    if (got !== exp) $display("Error %0t %h %h", $time, got, exp);
  endtask
  task automatic complete_run;
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic expiry_check;
    enable_write = 1'h1;
    @(negedge clock) enable_write = 1'h0;
    timeout_load = 1'h1;
    @(negedge clock) timeout_load = 1'h0;
    for (n = 1; warm_reset_req !== 1'h1 && n < 99; n++) @(negedge clock);
    chk(n, 32'h0000_0015);
    chk(CNT_W'(reset_out), 32'h0000_0001);
    repeat (30) @(negedge clock);
    chk(count, 32'h0000_001A);
    rst_b = 1'h0;
    @(negedge clock) rst_b = 1'h1;
    chk(CNT_W'(active), 32'h0000_0000);
  endtask
  // kick, a refused zero timeout and a disable write, after a power-on reset
  task automatic service_check;
    enable_write = 1'h1;
    @(negedge clock) enable_write = 1'h0;
    timeout_load = 1'h1;
    @(negedge clock) timeout_load = 1'h0;
    repeat (10) @(negedge clock);
    kick = 1'h1;
    @(negedge clock) kick = 1'h0;
    chk(count, 32'h0000_0000);
    repeat (15) @(negedge clock);
    chk(count, 32'h0000_000F);
    timeout_ticks = 32'h0000_0000;
    timeout_load = 1'h1;
    @(negedge clock) timeout_load = 1'h0;
    for (n = 1; warm_reset_req !== 1'h1 && n < 99; n++) @(negedge clock);
    chk(n, 32'h0000_0015);
    repeat (6) @(negedge clock);
    enable_write = 1'h1;
    enable_value = 1'h0;
    @(negedge clock) enable_write = 1'h0;
    repeat (2) @(negedge clock);
    chk(CNT_W'(active), 32'h0000_0000);
    chk(count, 32'h0000_0000);
  endtask
  initial begin
    repeat (12) @(negedge clock);
    rst_b = 1'h1;
    chk(CNT_W'(active), 32'h0000_0000);
    expiry_check();
    service_check();
    complete_run();
  end
  initial begin
    #2000 err_count++;
    complete_run();
  end
endmodule
bind wrwdt_top wrwdt_asserts chk_u (
  .clock          (clock),
  .rst_b          (rst_b),
  .warm_rst_b     (warm_rst_b),
  .enable_write   (enable_write),
  .enable_value   (enable_value),
  .timeout_load   (timeout_load),
  .kick           (kick),
  .warm_reset_req (warm_reset_req),
  .reset_out      (reset_out),
  .active         (active),
  .count          (count)
);
